// [design/fmp_map.svh]
// fmp_map.svh: offsets, field positions, reset values and sizes
// assumes: included by the package only, by its bare name
`ifndef FMP_MAP_SVH
`define FMP_MAP_SVH
// ****************************************
// array geometry
// ****************************************
`define FMP_WORDS      10'h300
`define FMP_LINES      9'h122
`define FMP_WORD_W     10
`define FMP_LINE_W     9
`define FMP_DATA_W     12
`define FMP_FIFO_D     4
// ****************************************
// register map (byte addresses)
// ****************************************
`define FMP_OFS_CTRL   8'h00
`define FMP_OFS_WPTR   8'h04
`define FMP_OFS_RPTR   8'h08
`define FMP_OFS_STAT   8'h0C
`define FMP_CTRL_RST   2'h3
`define FMP_CTRL_WEN   0
`define FMP_CTRL_REN   1
`define FMP_PTR_LINE   16
`define FMP_STAT_PEND  4
`endif

// [design/fmp_pkg.sv]
// fmp_pkg.sv: types and shared decode for the field memory pointers
// assumes: fmp_map.svh on the include path
package fmp_pkg;
`include "fmp_map.svh"
  typedef enum logic [6:0] {
    M_NONE  = 7'b000_0001,
    M_ADV   = 7'b000_0010,
    M_HOLD  = 7'b000_0100,
    M_RESET = 7'b000_1000,
    M_INC   = 7'b001_0000,
    M_JUMP  = 7'b010_0000,
    M_SETUP = 7'b100_0000
  } fmp_mode_t;
  typedef struct packed {
    logic [`FMP_WORD_W-1:0] word;
    logic [`FMP_DATA_W-1:0] data;
  } fmp_wentry_t;
  // word pointer step with wrap at line end
  function automatic logic [`FMP_WORD_W-1:0] fmp_word_inc(
    input logic [`FMP_WORD_W-1:0] w);
    fmp_word_inc = (w == `FMP_WORDS - 10'h001) ? 10'h000 : w + 10'h001;
  endfunction
  // mode decode; the write port has no line hold
  function automatic fmp_mode_t fmp_decode(input logic ctl,
    input logic step, input logic load, input logic adv, input logic rd);
    if (ctl)
    begin
      case ({step, load})
        2'b01:   fmp_decode = M_RESET;
        2'b10:   fmp_decode = M_INC;
        2'b11:   fmp_decode = M_JUMP;
        default: fmp_decode = rd ? M_HOLD : M_NONE;
      endcase
    end
    else if (!step && load)
      fmp_decode = M_SETUP;
    else if (!step && adv)
      fmp_decode = M_ADV;
    else
      fmp_decode = M_NONE;
  endfunction
endpackage

// [design/fmp_fifo.sv]
// fmp_fifo.sv: small flop fifo, valid and ready on both sides
// assumes: one clock, synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module fmp_fifo #(
  parameter int W = 22,
  parameter int D = 4,
  parameter int CW = $clog2(D + 1)
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data,
  output logic [CW-1:0]     o_count
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_idx_reg;
  logic [AW-1:0] rd_idx_reg;
  logic          push;
  logic          pop;
  assign o_in_ready  = (o_count != CW'(D));
  assign o_out_valid = (o_count != '0);
  assign o_out_data  = mem[rd_idx_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  // storage, written only when room is there
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_idx_reg] <= i_in_data;
  end
  // indices wrap at depth, so depth need not be a power of two
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wr_idx_reg <= '0;
      rd_idx_reg <= '0;
      o_count    <= '0;
    end
    else
    begin
      if (push)
        wr_idx_reg <= (wr_idx_reg == AW'(D - 1)) ? '0 : wr_idx_reg + 1'b1;
      if (pop)
        rd_idx_reg <= (rd_idx_reg == AW'(D - 1)) ? '0 : rd_idx_reg + 1'b1;
      o_count <= o_count + CW'(push) - CW'(pop);
    end
  end
endmodule
`default_nettype wire

// [design/fmp_port_ptr.sv]
// fmp_port_ptr.sv: line and word pointers of one serial port
// assumes: i_en is the port's own cycle enable, mode decoded outside
`timescale 1ns/1ps
`default_nettype none
module fmp_port_ptr
  import fmp_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  // port cycle
  input  wire logic                   i_en,
  input  wire fmp_mode_t              i_mode,
  input  wire logic                   i_ser_bit,
  // pointers
  output logic [`FMP_LINE_W-1:0]      o_line,
  output logic [`FMP_WORD_W-1:0]      o_word
);
  logic [`FMP_LINE_W-1:0] init_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      init_reg <= '0;
    else if (i_en && i_mode == M_SETUP)
      init_reg <= {init_reg[`FMP_LINE_W-2:0], i_ser_bit};
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_line <= '0;
      o_word <= '0;
    end
    else if (i_en)
    begin
      case (i_mode)
        M_ADV:   o_word <= fmp_word_inc(o_word);
        M_HOLD:  o_word <= '0;
        M_RESET:
        begin
          o_line <= '0;
          o_word <= '0;
        end
        M_INC:
        begin
          // wraps after the last line so a field restarts cleanly
          o_line <= (o_line == `FMP_LINES - 9'h001) ? '0 : o_line + 9'h001;
          o_word <= '0;
        end
        M_JUMP:
        begin
          o_line <= init_reg;
          o_word <= '0;
        end
        default: o_word <= o_word;
      endcase
    end
  end
  a_reset_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    i_en && i_mode == M_RESET |=> o_line == '0 && o_word == '0)
    else $error("reset mode left a pointer nonzero");
  a_line_step: assert property (@(posedge i_clk) disable iff (i_srst)
    i_en && i_mode == M_INC && o_line == 9'h005
    |=> o_line == 9'h006 && o_word == '0)
    else $error("line increment wrong");
  a_jump_reload: assert property (@(posedge i_clk) disable iff (i_srst)
    i_en && i_mode == M_JUMP |=> o_line == $past(init_reg) && o_word == '0)
    else $error("jump did not reload line");
  a_hold_line: assert property (@(posedge i_clk) disable iff (i_srst)
    i_en && i_mode == M_HOLD |=> $stable(o_line) && o_word == '0)
    else $error("line hold moved the line");
endmodule
`default_nettype wire

// [design/fmp_top.sv]
// fmp_top.sv: serial write and read port pointer control, AHB-Lite regs
// assumes: port cycle enables are synchronous one-cycle pulses of
// I_CLOCK; the cell array answers reads in the same cycle
`timescale 1ns/1ps
`default_nettype none
module fmp_top
  import fmp_pkg::*;
(
  // clock and reset
  input  wire logic                   I_CLOCK,
  input  wire logic                   I_SRST,
  // ahb-lite slave
  input  wire logic                   I_HSEL,
  input  wire logic [31:0]            I_HADDR,
  input  wire logic [1:0]             I_HTRANS,
  input  wire logic                   I_HWRITE,
  input  wire logic [2:0]             I_HSIZE,
  input  wire logic [31:0]            I_HWDATA,
  input  wire logic                   I_HREADY,
  output logic [31:0]                 O_HRDATA,
  output logic                        O_HREADYOUT,
  output logic                        O_HRESP,
  // write port
  input  wire logic                   I_WR_CLK_EN,
  input  wire logic                   I_WR_EN,
  input  wire logic                   I_WR_DATA_MASK,
  input  wire logic                   I_WR_TRANSFER_STROBE,
  input  wire logic                   I_WR_LINE_STEP,
  input  wire logic                   I_WR_ADDR_LOAD_CTRL,
  input  wire logic                   I_WR_SERIAL_LINE_ADDR,
  input  wire logic [`FMP_DATA_W-1:0] I_WR_DIN,
  output logic                        O_WR_READY,
  // read port
  input  wire logic                   I_RD_CLK_EN,
  input  wire logic                   I_RD_ADVANCE_GATE,
  input  wire logic                   I_RD_OE,
  input  wire logic                   I_RD_LINE_CTRL,
  input  wire logic                   I_RD_LINE_STEP,
  input  wire logic                   I_RD_ADDR_LOAD_CTRL,
  input  wire logic                   I_RD_SERIAL_LINE_ADDR,
  output logic [`FMP_DATA_W-1:0]      O_DOUT,
  output logic                        O_DOUT_OE,
  // cell array side
  input  wire logic                   I_ARR_WREADY,
  output logic                        O_ARR_WE,
  output logic [`FMP_WORD_W-1:0]      O_ARR_WADDR,
  output logic [`FMP_DATA_W-1:0]      O_ARR_WDATA,
  output logic                        O_COMMIT,
  output logic [`FMP_LINE_W-1:0]      O_COMMIT_LINE,
  input  wire logic [`FMP_DATA_W-1:0] I_ARR_RDATA,
  output logic [`FMP_LINE_W-1:0]      O_RD_LINE,
  output logic [`FMP_WORD_W-1:0]      O_RD_WORD
);
  // ****************************************
  // declarations
  // ****************************************
  localparam int FW = $bits(fmp_wentry_t);
  localparam int CW = $clog2(`FMP_FIFO_D + 1);
  logic [1:0]             ctrl_reg;
  logic                   addr_ok_reg;
  logic                   wr_ph_reg;
  logic [7:0]             ofs_reg;
  logic                   pend_reg;
  logic                   pend_next;
  logic [`FMP_LINE_W-1:0] wr_line;
  logic [`FMP_WORD_W-1:0] wr_word;
  logic [CW-1:0]          fifo_cnt;
  logic                   fifo_in_ready;
  logic                   fifo_valid;
  fmp_wentry_t            fifo_out;
  fmp_wentry_t            push_ent;
  fmp_mode_t              wr_mode;
  fmp_mode_t              rd_mode;
  logic                   wr_take;
  logic                   rd_take;
  logic                   push;
  logic                   addr_ph;
  logic                   commit_go;
  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign addr_ph = I_HSEL && I_HTRANS[1] && I_HREADY;
  // address phase capture; zero wait states, always OKAY
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      wr_ph_reg   <= 1'b0;
      ofs_reg     <= 8'h00;
      addr_ok_reg <= 1'b0;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end
    else if (I_HREADY)
    begin
      wr_ph_reg   <= addr_ph && I_HWRITE;
      ofs_reg     <= I_HADDR[7:0];
      addr_ok_reg <= (I_HADDR[31:8] == 24'h00_0000);
    end
  end
  // read data loaded in the address phase so it stands in the data phase
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
      O_HRDATA <= 32'h0000_0000;
    else if (addr_ph && !I_HWRITE)
    begin
      O_HRDATA <= 32'h0000_0000;
      if (I_HADDR[31:8] == 24'h00_0000)
      begin
        case (I_HADDR[7:0])
          `FMP_OFS_CTRL: O_HRDATA <= {30'h0000_0000, ctrl_reg};
          `FMP_OFS_WPTR: O_HRDATA <= {7'h00, wr_line, 6'h00, wr_word};
          `FMP_OFS_RPTR: O_HRDATA <= {7'h00, O_RD_LINE, 6'h00, O_RD_WORD};
          `FMP_OFS_STAT: O_HRDATA <= {27'h000_0000, pend_reg,
                                      1'b0, fifo_cnt};
          default:       O_HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
  // control: port enables; other offsets are read only
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
      ctrl_reg <= `FMP_CTRL_RST;
    else if (wr_ph_reg && addr_ok_reg && ofs_reg == `FMP_OFS_CTRL)
      ctrl_reg <= I_HWDATA[1:0];
  end
  // ****************************************
  // write port
  // ****************************************
  // write decode without hold
  assign wr_mode = fmp_decode(I_WR_TRANSFER_STROBE, I_WR_LINE_STEP,
                              I_WR_ADDR_LOAD_CTRL, I_WR_EN, 1'b0);
  // a cycle offered while not ready is ignored whole
  assign wr_take = I_WR_CLK_EN && O_WR_READY && ctrl_reg[`FMP_CTRL_WEN];
  // masked word advances but is not stored
  assign push = wr_take && wr_mode == M_ADV && I_WR_DATA_MASK;
  assign push_ent.word = wr_word;
  assign push_ent.data = I_WR_DIN;
  // write pointer stepped by write cycles only
  fmp_port_ptr u_wr_ptr (
    .i_clk     (I_CLOCK),
    .i_srst    (I_SRST),
    .i_en      (wr_take),
    .i_mode    (wr_mode),
    .i_ser_bit (I_WR_SERIAL_LINE_ADDR),
    .o_line    (wr_line),
    .o_word    (wr_word)
  );
  fmp_fifo #(
    .W (FW),
    .D (`FMP_FIFO_D)
  ) u_fifo (
    .i_clk       (I_CLOCK),
    .i_srst      (I_SRST),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_ent),
    .o_out_valid (fifo_valid),
    .i_out_ready (I_ARR_WREADY),
    .o_out_data  (fifo_out),
    .o_count     (fifo_cnt)
  );
  // line write staging into the array buffer, stalls on array ready
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      O_ARR_WE    <= 1'b0;
      O_ARR_WADDR <= '0;
      O_ARR_WDATA <= '0;
    end
    else
    begin
      O_ARR_WE <= fifo_valid && I_ARR_WREADY;
      if (fifo_valid && I_ARR_WREADY)
      begin
        O_ARR_WADDR <= fifo_out.word;
        O_ARR_WDATA <= fifo_out.data;
      end
    end
  end
  // commit waits until every earlier word has reached the array
  assign commit_go = pend_reg && !fifo_valid && !O_ARR_WE;
  always_comb
  begin
    pend_next = pend_reg;
    if (commit_go)
      pend_next = 1'b0;
    if (wr_take && I_WR_TRANSFER_STROBE)
      pend_next = 1'b1;
  end
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      pend_reg      <= 1'b0;
      O_COMMIT      <= 1'b0;
      O_COMMIT_LINE <= '0;
    end
    else
    begin
      pend_reg <= pend_next;
      O_COMMIT <= commit_go;
      // line captured before the strobe's own mode moves the pointer
      if (wr_take && I_WR_TRANSFER_STROBE)
        O_COMMIT_LINE <= wr_line;
    end
  end
  // ready lags a cycle, so keep one spare slot; a pending commit stalls
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
      O_WR_READY <= 1'b0;
    else
      O_WR_READY <= !pend_next && fifo_in_ready
                    && fifo_cnt <= CW'(`FMP_FIFO_D - 2);
  end
  // ****************************************
  // read port
  // ****************************************
  // read decode with hold
  assign rd_mode = fmp_decode(I_RD_LINE_CTRL, I_RD_LINE_STEP,
                              I_RD_ADDR_LOAD_CTRL, I_RD_ADVANCE_GATE, 1'b1);
  assign rd_take = I_RD_CLK_EN && ctrl_reg[`FMP_CTRL_REN];
  fmp_port_ptr u_rd_ptr (
    .i_clk     (I_CLOCK),
    .i_srst    (I_SRST),
    .i_en      (rd_take),
    .i_mode    (rd_mode),
    .i_ser_bit (I_RD_SERIAL_LINE_ADDR),
    .o_line    (O_RD_LINE),
    .o_word    (O_RD_WORD)
  );
  // data taken only on advancing cycles
  // drive follows the output control each read cycle
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      O_DOUT    <= '0;
      O_DOUT_OE <= 1'b0;
    end
    else if (rd_take)
    begin
      O_DOUT_OE <= I_RD_OE;
      if (rd_mode == M_ADV)
        O_DOUT <= I_ARR_RDATA;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  a_wen_hold: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    wr_take && wr_mode == M_NONE && !I_WR_TRANSFER_STROBE
    |-> !push ##1 wr_word == $past(wr_word))
    else $error("write pointer moved with enable low");
  a_mask_skip: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    wr_take && wr_mode == M_ADV && !I_WR_DATA_MASK
    |-> !push ##1 wr_word == fmp_word_inc($past(wr_word)))
    else $error("masked cycle wrong");
  a_commit_order: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    O_COMMIT |-> $past(pend_reg) && !$past(fifo_valid) && !$past(O_ARR_WE))
    else $error("commit before line drained");
  a_rd_hold: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    rd_take && rd_mode == M_NONE && !I_RD_LINE_CTRL
    |=> $stable(O_DOUT) && $stable(O_RD_WORD))
    else $error("read moved with gate low");
  a_oe_float: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    rd_take && !I_RD_OE |=> !O_DOUT_OE)
    else $error("outputs driven with drive low");
  a_oe_skip: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    rd_take && !I_RD_OE && rd_mode == M_ADV
    |=> O_RD_WORD == fmp_word_inc($past(O_RD_WORD)))
    else $error("skipped word not advanced");
endmodule
`default_nettype wire

// [verification/fmp_array_model.sv]
// fmp_array_model.sv: cell array stand-in at the far side of the block
// assumes: one clock shared with the block; bench reads counters by path
`timescale 1ns/1ps
`default_nettype none
module fmp_array_model
  import fmp_pkg::*;
(
  // clock and stall request
  input  wire logic                   i_clk,
  input  wire logic                   i_stall,
  // write side
  output logic                        o_wready,
  input  wire logic                   i_we,
  input  wire logic [`FMP_WORD_W-1:0] i_waddr,
  input  wire logic [`FMP_DATA_W-1:0] i_wdata,
  input  wire logic                   i_commit,
  input  wire logic [`FMP_LINE_W-1:0] i_cline,
  // read side
  input  wire logic [`FMP_LINE_W-1:0] i_line,
  input  wire logic [`FMP_WORD_W-1:0] i_word,
  output logic [`FMP_DATA_W-1:0]      o_rdata
);
  // ****
  // traffic record
  // ****
  int                     n_wr = 0;
  int                     n_cm = 0;
  logic [`FMP_WORD_W-1:0] waddr_reg = '0;
  logic [`FMP_DATA_W-1:0] wdata_reg = '0;
  logic [`FMP_LINE_W-1:0] cline_reg = '0;
  // content follows the address, so a skipped word is visible
  assign o_rdata = {i_line[1:0], i_word};
  // slow at random; a bench stall holds the array off entirely
  always @(posedge i_clk)
    o_wready <= !i_stall && ($urandom_range(3) != 0);
  // stored words
  always @(posedge i_clk)
    if (i_we)
    begin
      n_wr <= n_wr + 1;
      waddr_reg <= i_waddr;
      wdata_reg <= i_wdata;
    end
  always @(posedge i_clk)
    if (i_commit)
    begin
      n_cm <= n_cm + 1;
      cline_reg <= i_cline;
    end
endmodule
`default_nettype wire

// [verification/fmp_top_tb.sv]
// fmp_top_tb.sv: self-checking bench for the field memory pointers
// assumes: array model beside the block, registers over ahb-lite
`timescale 1ns/1ps
`default_nettype none
module fmp_top_tb
  import fmp_pkg::*;
;
  // ****
  // design inputs; all that the bench drives are valued at time zero
  // ****
  logic I_CLOCK = 0, I_SRST = 1, I_HSEL = 0, I_HWRITE = 0, stall = 0;
  logic [31:0] I_HADDR = '0, I_HWDATA = '0, rd;
  logic [1:0] I_HTRANS = '0;
  logic [2:0] I_HSIZE = 3'h2;
  logic I_WR_CLK_EN = 0, I_WR_EN = 0, I_WR_DATA_MASK = 0;
  logic I_WR_TRANSFER_STROBE = 0, I_WR_LINE_STEP = 0;
  logic I_WR_ADDR_LOAD_CTRL = 0, I_WR_SERIAL_LINE_ADDR = 0;
  logic [11:0] I_WR_DIN = '0, O_DOUT, O_ARR_WDATA, I_ARR_RDATA;
  logic I_RD_CLK_EN = 0, I_RD_ADVANCE_GATE = 0, I_RD_OE = 0;
  logic I_RD_LINE_CTRL = 0, I_RD_LINE_STEP = 0;
  logic I_RD_ADDR_LOAD_CTRL = 0, I_RD_SERIAL_LINE_ADDR = 0;
  logic I_HREADY, I_ARR_WREADY, O_HREADYOUT, O_HRESP, O_WR_READY;
  logic O_DOUT_OE, O_ARR_WE, O_COMMIT;
  logic [31:0] O_HRDATA;
  logic [9:0] O_ARR_WADDR, O_RD_WORD, ww = '0, rw = '0, st_a;
  logic [8:0] O_COMMIT_LINE, O_RD_LINE, wl = '0, rl = '0;
  logic [8:0] wi = '0, ri = '0, cm_l;
  logic [11:0] st_d, x_do;
  logic ok, x_oe, dv = 0;
  int miscompares = 0, num_checks = 0, n_st = 0, n_cm = 0, acc;
  // the one slave's ready is the bus ready
  assign I_HREADY = O_HREADYOUT;
  fmp_top dut (.I_CLOCK, .I_SRST, .I_HSEL, .I_HADDR, .I_HTRANS,
    .I_HWRITE, .I_HSIZE, .I_HWDATA, .I_HREADY, .O_HRDATA, .O_HREADYOUT,
    .O_HRESP, .I_WR_CLK_EN, .I_WR_EN, .I_WR_DATA_MASK,
    .I_WR_TRANSFER_STROBE, .I_WR_LINE_STEP, .I_WR_ADDR_LOAD_CTRL,
    .I_WR_SERIAL_LINE_ADDR, .I_WR_DIN, .O_WR_READY, .I_RD_CLK_EN,
    .I_RD_ADVANCE_GATE, .I_RD_OE, .I_RD_LINE_CTRL, .I_RD_LINE_STEP,
    .I_RD_ADDR_LOAD_CTRL, .I_RD_SERIAL_LINE_ADDR, .O_DOUT, .O_DOUT_OE,
    .I_ARR_WREADY, .O_ARR_WE, .O_ARR_WADDR, .O_ARR_WDATA, .O_COMMIT,
    .O_COMMIT_LINE, .I_ARR_RDATA, .O_RD_LINE, .O_RD_WORD);
  fmp_array_model array (.i_clk(I_CLOCK), .i_stall(stall),
    .o_wready(I_ARR_WREADY), .i_we(O_ARR_WE), .i_waddr(O_ARR_WADDR),
    .i_wdata(O_ARR_WDATA), .i_commit(O_COMMIT), .i_cline(O_COMMIT_LINE),
    .i_line(O_RD_LINE), .i_word(O_RD_WORD), .o_rdata(I_ARR_RDATA));
  // 10 MHz clock
  initial
    forever #50 I_CLOCK = ~I_CLOCK;
  // ****
  // shared tasks
  // ****
  task automatic print_verdict();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a spent wait counts once, then ends the run
  task automatic give_up();
    miscompares++;
    print_verdict();
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // expected port cycle result, packed as {line, word, initial line}
  function automatic logic [27:0] nxt(input logic [27:0] p,
    input logic ctl, step, load, adv, ser, rdp);
    logic [8:0] l;
    logic [9:0] w;
    logic [8:0] i;
    {l, w, i} = p;
    if (ctl)
      case ({step, load})
        2'b01: {l, w} = '0;
        2'b10: {l, w} = {(l == `FMP_LINES - 9'h001) ? 9'h000 : l + 9'h001,
          10'h000};
        2'b11: {l, w} = {i, 10'h000};
        default: w = rdp ? 10'h000 : w;
      endcase
    else if (!step && load)
      i = {i[7:0], ser};
    else if (!step && adv)
      w = (w == `FMP_WORDS - 10'h001) ? 10'h000 : w + 10'h001;
    return {l, w, i};
  endfunction
  task automatic hwait();
    int k;
    for (k = 0; k < 20; k++)
    begin
      @(posedge I_CLOCK);
      if (O_HREADYOUT)
        break;
    end
    if (k == 20)
      give_up();
  endtask
  // one single word transfer; read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge I_CLOCK);
    {I_HSEL, I_HWRITE, I_HTRANS, I_HADDR} <= {1'b1, w, 2'b10, a};
    hwait();
    {I_HTRANS, I_HWDATA} <= {2'b00, d};
    hwait();
    rd = O_HRDATA;
  endtask
  task automatic wptr_chk();
    ahb(0, 32'(`FMP_OFS_WPTR), 0);
    chk("write line", wl, 32'(rd[24:16]));
    chk("write word", ww, 32'(rd[9:0]));
  endtask
  // one write cycle, held until accepted or the wait is spent
  task automatic wcyc(input logic en, m, s, st, ld, sr, must,
    input logic [11:0] d);
    @(posedge I_CLOCK);
    {I_WR_EN, I_WR_DATA_MASK, I_WR_TRANSFER_STROBE, I_WR_LINE_STEP,
      I_WR_ADDR_LOAD_CTRL, I_WR_SERIAL_LINE_ADDR, I_WR_CLK_EN, I_WR_DIN}
      <= {en, m, s, st, ld, sr, 1'b1, d};
    ok = 0;
    for (int k = 0; k < 20 && !ok; k++)
    begin
      @(posedge I_CLOCK);
      ok = O_WR_READY;
    end
    I_WR_CLK_EN <= 0;
    if (!ok && must)
      give_up();
    if (ok && s)
      {n_cm, cm_l} = {n_cm + 1, wl};
    if (ok && !s && !st && !ld && en && m)
      {n_st, st_a, st_d} = {n_st + 1, ww, d};
    if (ok)
      {wl, ww, wi} = nxt({wl, ww, wi}, s, st, ld, en, sr, 0);
  endtask
  // one read cycle; pointers and output checked once settled
  task automatic rcyc(input logic g, oe, c, st, ld, sr);
    @(posedge I_CLOCK);
    {I_RD_ADVANCE_GATE, I_RD_OE, I_RD_LINE_CTRL, I_RD_LINE_STEP,
      I_RD_ADDR_LOAD_CTRL, I_RD_SERIAL_LINE_ADDR, I_RD_CLK_EN}
      <= {g, oe, c, st, ld, sr, 1'b1};
    @(posedge I_CLOCK);
    I_RD_CLK_EN <= 0;
    @(negedge I_CLOCK);
    // drive follows the output control on every read cycle
    if (!c && !st && !ld && g)
      {dv, x_do} = {1'b1, rl[1:0], rw};
    else if (c || ld)
      dv = 0;
    x_oe = oe;
    {rl, rw, ri} = nxt({rl, rw, ri}, c, st, ld, g, sr, 1);
    chk("read line", rl, O_RD_LINE);
    chk("read word", rw, O_RD_WORD);
    chk("drive", x_oe, O_DOUT_OE);
    if (dv && x_oe)
      chk("read data", x_do, O_DOUT);
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 300; k++)
    begin
      @(posedge I_CLOCK);
      if (array.n_wr == n_st && array.n_cm == n_cm)
        break;
    end
    if (k == 300)
      give_up();
    chk("stored", n_st, array.n_wr);
    chk("addr", st_a, array.waddr_reg);
    chk("data", st_d, array.wdata_reg);
    chk("commit line", cm_l, array.cline_reg);
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    void'($urandom(69));
    repeat (16) @(posedge I_CLOCK);
    I_SRST <= 0;
    // registers: reset value, read back, unmapped place
    ahb(0, 32'(`FMP_OFS_CTRL), 0);
    chk("ctrl reset", 3, rd);
    ahb(1, 32'h0000_0010, 32'h5555_5555);
    ahb(0, 32'h0000_0010, 0);
    chk("unmapped", 0, rd);
    chk("hresp", 0, O_HRESP);
    ahb(1, 32'(`FMP_OFS_CTRL), 1);
    ahb(0, 32'(`FMP_OFS_CTRL), 0);
    chk("ctrl rw", 1, rd);
    ahb(1, 32'(`FMP_OFS_CTRL), 3);
    // set the last line as initial line, jump to it, step over the end
    for (int b = 8; b >= 0; b--)
    begin
      wcyc(0, 0, 0, 0, 1, 9'h121 >> b, 1, 0);
      rcyc(0, 0, 0, 0, 1, 9'h121 >> b);
    end
    wcyc(1, 1, 1, 1, 1, 0, 1, 0);
    wptr_chk();
    rcyc(0, 1, 1, 1, 1, 0);
    wcyc(1, 1, 1, 1, 0, 0, 1, 0);
    wptr_chk();
    rcyc(0, 1, 1, 1, 0, 0);
    // random write traffic with mode cycles among it
    repeat (60)
    begin
      if ($urandom_range(9) < 7)
        wcyc($urandom_range(3) != 0, $urandom, 0, 0, 0, 0, 1, $urandom);
      else
        wcyc($urandom, 1, 1, $urandom, $urandom, 0, 1, $urandom);
      wptr_chk();
    end
    drain();
    // random read traffic over every mode but setup
    repeat (80)
    begin
      acc = $urandom_range(6);
      acc = acc + (acc > 0);
      rcyc($urandom, $urandom, acc[2], acc[1], acc[0], 0);
    end
    // fill the buffer with the array stalled until refused
    stall <= 1;
    acc = 0;
    ok = 1;
    for (int i = 0; i < 8 && ok; i++)
    begin
      wcyc(1, 1, 0, 0, 0, 0, 0, $urandom);
      acc += ok;
    end
    chk("refused", 0, ok);
    chk("fill depth", 1, acc >= 1 && acc <= `FMP_FIFO_D + 1);
    stall <= 0;
    drain();
    wptr_chk();
    print_verdict();
  end
endmodule
`default_nettype wire
